/* File: rtl/owc_pkg.sv */
/*
  Package for the oscillator warm-up counter: register offsets, field
  positions, reset values, the control mode codes and the bus carriers.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
`default_nettype none
package owc_pkg;

  // ********************************************************************
  // Register byte offsets.
  // ********************************************************************
  localparam logic [11:0] OFS_LOWER_CTRL = 12'h000;
  localparam logic [11:0] OFS_UPPER_CTRL = 12'h004;
  localparam logic [11:0] OFS_COMPARE = 12'h008;
  localparam logic [11:0] OFS_COUNT = 12'h00c;
  localparam logic [11:0] OFS_SYS_CTRL = 12'h010;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h014;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h018;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int UPPER_FF_INIT_BIT = 7;
  localparam int RUN_BIT = 3;
  localparam int LOWER_FF_INIT_BIT = 7;
  localparam int SYSCLK_SEL_BIT = 5;
  localparam int LF_OSC_EN_BIT = 6;
  localparam int HF_OSC_EN_BIT = 7;
  localparam int IRQ_MATCH_BIT = 0;

  // ********************************************************************
  // Mode codes and reset values.
  // ********************************************************************
  localparam logic [2:0] UPPER_MODE_WARMUP = 3'h5;
  localparam logic [5:0] LOWER_MODE_CASCADE = 6'h03;
  localparam logic [1:0] LOWER_SRC_LF = 2'h2;
  localparam logic [1:0] LOWER_SRC_HF = 2'h3;
  localparam logic [7:0] LOWER_CTRL_RST = 8'h00;
  localparam logic [7:0] UPPER_CTRL_RST = 8'h00;
  localparam logic [15:0] COMPARE_RST = 16'hffff;
  localparam logic [7:0] SYS_CTRL_RST = 8'h80;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } owc_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic slverr;
  } owc_rsp_t;

endpackage
`default_nettype wire

/* File: rtl/owc_counter.sv */
/*
  Cascaded 16-bit up-counter with a match on the upper byte only.
  Assumes a one-cycle count enable from the selected source clock.
*/
`timescale 1ns/1ps
`default_nettype none
module owc_counter #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick,
  input wire logic [WIDTH-1:0] compare,
  output logic [WIDTH-1:0] count,
  output logic match
);

  logic [WIDTH-1:0] count_r;

  // Only the upper byte is compared; the low byte is ignored.
  assign match = run && tick &&
    (count_r[WIDTH-1:8] == compare[WIDTH-1:8]); // see RULE2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (!run) begin
      count_r <= '0; // see RULE15
    end else if (match) begin
      count_r <= '0; // see RULE4
    end else if (tick) begin
      count_r <= count_r + WIDTH'(1); // see RULE1
    end
  end

  assign count = count_r;

endmodule
`default_nettype wire

/* File: rtl/owc_top.sv */
/*
  Oscillator warm-up counter with APB registers and a match interrupt.
  Assumes lf_tick and hf_tick are one-cycle enables on pclk, one per
  period of the low- and high-frequency oscillator.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Warm-up mode chains both 8-bit counters into one 16-bit up-counter.
// RULE2: Match compares only the upper compare byte; low byte is ignored.
// RULE3: Software keeps both flip-flop initial bits at zero in warm-up.
// RULE4: On match the counter clears and the match interrupt is raised.
// RULE5: Run bit 3 of upper control starts counting; clearing it stops.
// RULE6: High-to-low switch: software enables low oscillator before start.
// RULE7: After interrupt: stop, select low clock, disable high oscillator.
// RULE8: Low-to-high switch: software enables high oscillator before start.
// RULE9: After interrupt: stop, select high clock, disable low oscillator.
// RULE10: Low source, compare 0100H gives 7.81 ms, FF00H about 1.99 s.
// RULE11: High source, compare 0100H gives 16 us, FF00H gives 4.08 ms.
// RULE12: Writing 05H to upper control selects warm-up, stopped.
// RULE13: Writing 43H to lower control selects low clock, cascaded.
// RULE14: System control bits: 5 clock select, 7 high en, 6 low en.
// RULE15: Clearing run stops, zeroes the count, and blocks further matches.
module owc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lf_tick,
  input wire logic hf_tick,
  output logic sysclk_sel_low,
  output logic hf_osc_en,
  output logic lf_osc_en,
  output logic warmup_match_irq
);

  // ********************************************************************
  // Bus decode.
  // ********************************************************************
  owc_pkg::owc_req_t req;
  owc_pkg::owc_rsp_t rsp;
  logic wr_en;
  logic known;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign wr_en = psel && penable && req.write;
  assign pready = 1'b1;

  always_comb begin
    known = 1'b1;
    case (req.addr)
      owc_pkg::OFS_LOWER_CTRL,
      owc_pkg::OFS_UPPER_CTRL,
      owc_pkg::OFS_COMPARE,
      owc_pkg::OFS_COUNT,
      owc_pkg::OFS_SYS_CTRL,
      owc_pkg::OFS_IRQ_STATUS,
      owc_pkg::OFS_IRQ_MASK: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // ********************************************************************
  // Control registers.
  // ********************************************************************
  logic [7:0] lower_timer_control_r;
  logic [7:0] upper_timer_control_r;
  logic [15:0] compare_r;
  logic [7:0] system_control_two_r;
  logic irq_status_r;
  logic irq_mask_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_timer_control_r <= owc_pkg::LOWER_CTRL_RST;
    end else if (wr_en && req.addr == owc_pkg::OFS_LOWER_CTRL) begin
      lower_timer_control_r <= req.wdata[7:0]; // see RULE13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_timer_control_r <= owc_pkg::UPPER_CTRL_RST;
    end else if (wr_en && req.addr == owc_pkg::OFS_UPPER_CTRL) begin
      upper_timer_control_r <= req.wdata[7:0]; // see RULE12
    end
  end

  // Both compare bytes are stored and read back; only the high one counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_r <= owc_pkg::COMPARE_RST;
    end else if (wr_en && req.addr == owc_pkg::OFS_COMPARE) begin
      compare_r <= req.wdata[15:0];
    end
  end

  // Oscillator enables and clock select are driven straight to the clock
  // generator; the order of switching is left to software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_two_r <= owc_pkg::SYS_CTRL_RST;
    end else if (wr_en && req.addr == owc_pkg::OFS_SYS_CTRL) begin
      system_control_two_r <= req.wdata[7:0]; // see RULE14
    end
  end

  assign sysclk_sel_low = system_control_two_r[owc_pkg::SYSCLK_SEL_BIT];
  assign hf_osc_en = system_control_two_r[owc_pkg::HF_OSC_EN_BIT];
  assign lf_osc_en = system_control_two_r[owc_pkg::LF_OSC_EN_BIT];

  // ********************************************************************
  // Mode decode and counter.
  // ********************************************************************
  logic warmup_mode;
  logic cascade_mode;
  logic cascade_run_bit;
  logic run;
  logic tick;
  logic match;
  logic [15:0] count;

  assign warmup_mode = upper_timer_control_r[2:0] ==
    owc_pkg::UPPER_MODE_WARMUP;
  assign cascade_mode = lower_timer_control_r[2:0] ==
    owc_pkg::LOWER_MODE_CASCADE[2:0];
  assign cascade_run_bit = upper_timer_control_r[owc_pkg::RUN_BIT];
  assign run = cascade_run_bit && warmup_mode && cascade_mode; // see RULE5

  // The count rate sets the warm-up time: each compare step is 256 ticks.
  // Bit 7 is left to the flip-flop initial value, so that either source
  // can be chosen while software keeps that bit at zero.
  always_comb begin
    case (lower_timer_control_r[6:5])
      owc_pkg::LOWER_SRC_LF: tick = lf_tick; // see RULE10
      owc_pkg::LOWER_SRC_HF: tick = hf_tick; // see RULE11
      default: tick = lf_tick;
    endcase
  end

  owc_counter #(
    .WIDTH(16)
  ) owc_counter_inst (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .tick(tick),
    .compare(compare_r),
    .count(count),
    .match(match)
  );

  // ********************************************************************
  // Interrupt.
  // ********************************************************************
  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 1'b0;
    end else if (match) begin
      irq_status_r <= 1'b1; // see RULE4
    end else if (wr_en && req.addr == owc_pkg::OFS_IRQ_STATUS &&
        req.wdata[owc_pkg::IRQ_MATCH_BIT]) begin
      irq_status_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= 1'b0;
    end else if (wr_en && req.addr == owc_pkg::OFS_IRQ_MASK) begin
      irq_mask_r <= req.wdata[owc_pkg::IRQ_MATCH_BIT];
    end
  end

  assign warmup_match_irq = irq_status_r && irq_mask_r;

  // ********************************************************************
  // Read path.
  // ********************************************************************
  always_comb begin
    rsp.rdata = 32'h0000_0000;
    rsp.slverr = psel && penable && !known;
    case (req.addr)
      owc_pkg::OFS_LOWER_CTRL: rsp.rdata[7:0] = lower_timer_control_r;
      owc_pkg::OFS_UPPER_CTRL: rsp.rdata[7:0] = upper_timer_control_r;
      owc_pkg::OFS_COMPARE: rsp.rdata[15:0] = compare_r;
      owc_pkg::OFS_COUNT: rsp.rdata[15:0] = count;
      owc_pkg::OFS_SYS_CTRL: rsp.rdata[7:0] = system_control_two_r;
      owc_pkg::OFS_IRQ_STATUS: rsp.rdata[0] = irq_status_r;
      owc_pkg::OFS_IRQ_MASK: rsp.rdata[0] = irq_mask_r;
      default: rsp.rdata = 32'h0000_0000;
    endcase
  end

  assign prdata = rsp.rdata;
  assign pslverr = rsp.slverr;

endmodule
`default_nettype wire

/* File: sim/owc_asserts.sv */
/*
  Port checker for the warm-up counter top.
  Assumes it is bound to owc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module owc_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lf_tick,
  input wire logic hf_tick,
  input wire logic sysclk_sel_low,
  input wire logic hf_osc_en,
  input wire logic lf_osc_en,
  input wire logic warmup_match_irq
);
  // ****************
  // Port relations.
  // ****************
  wire logic acc = psel & penable;
  wire logic bad = acc & ((paddr > owc_pkg::OFS_IRQ_MASK) |
    (paddr[1:0] != 2'h0));
  wire logic wr = acc & pwrite;
  wire logic [2:0] sys_bits = pwdata[7:5];
  wire logic cause = lf_tick | hf_tick | wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err; bad |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  property p_ok; acc && !bad |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("bad slverr");
  property p_hole; bad && !pwrite |-> prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole data");
  property p_sys;
    wr && paddr == owc_pkg::OFS_SYS_CTRL |=>
      {hf_osc_en, lf_osc_en, sysclk_sel_low} == $past(sys_bits);
  endproperty
  a_sys: assert property (p_sys) else $error("sys pins");
  property p_mask;
    wr && paddr == owc_pkg::OFS_IRQ_MASK && !pwdata[0] |=>
      !warmup_match_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_w1c;
    wr && paddr == owc_pkg::OFS_IRQ_STATUS && pwdata[0] && !lf_tick &&
      !hf_tick |=> !warmup_match_irq;
  endproperty
  a_w1c: assert property (p_w1c) else $error("irq kept");
  property p_hold; warmup_match_irq && !wr |=> warmup_match_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq lost");
  property p_rise; $rose(warmup_match_irq) |-> $past(cause); endproperty
  a_rise: assert property (p_rise) else $error("irq no cause");
  c_irq: cover property ($rose(warmup_match_irq));
  c_bad: cover property (bad);
  c_sys: cover property (wr && paddr == owc_pkg::OFS_SYS_CTRL);
endmodule
`default_nettype wire

/* File: sim/owc_top_test.sv */
/*
  Self-checking bench for the warm-up counter over APB.
  Assumes owc_pkg and owc_top are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module owc_top_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, sv, lf_tick = 0, hf_tick = 0;
  logic sysclk_sel_low, hf_osc_en, lf_osc_en, warmup_match_irq;
  logic lf_on = 0, hf_on = 0, hs = 0;
  int n_errors = 0, checked = 0, nt = 0;
  owc_top owc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lf_tick(lf_tick), .hf_tick(hf_tick), .sysclk_sel_low(sysclk_sel_low),
    .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
    .warmup_match_irq(warmup_match_irq));
  // ****************
  // Clock and ticks.
  // ****************
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) begin
    lf_tick <= lf_on & ~lf_tick;
    hf_tick <= hf_on;
    if (hs ? hf_tick : lf_tick) nt++;
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic acc(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    sv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, string s);
    acc(a, 1'b0, 32'h0);
    chk(s, e, rv);
  endtask
  task automatic wi(input logic [31:0] e, input string s);
    int k;
    k = 0;
    while (warmup_match_irq !== 1'b1 && k < 3000) begin
      @(negedge pclk);
      k++;
    end
    lf_on = 0;
    hf_on = 0;
    chk(s, e, nt);
    @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(owc_pkg::OFS_COMPARE, 32'hffff, "cmp");
    rd(owc_pkg::OFS_SYS_CTRL, 32'h80, "sys");
    rd(owc_pkg::OFS_UPPER_CTRL, 32'h0, "upper");
    rd(12'h01c, 32'h0, "hole");
    chk("slverr", 32'h1, 32'(sv));
    wr(owc_pkg::OFS_SYS_CTRL, 32'hc0);
    chk("lf en", 32'h1, 32'(lf_osc_en));
    wr(owc_pkg::OFS_LOWER_CTRL, 32'h43);
    wr(owc_pkg::OFS_UPPER_CTRL, 32'h05);
    wr(owc_pkg::OFS_COMPARE, 32'h02ff);
    wr(owc_pkg::OFS_IRQ_MASK, 32'h1);
    wr(owc_pkg::OFS_UPPER_CTRL, 32'h0d);
    nt = 0;
    lf_on <= 1;
    wi(32'd513, "lf ticks");
    rd(owc_pkg::OFS_COUNT, 32'h0, "clr");
    wr(owc_pkg::OFS_UPPER_CTRL, 32'h05);
    wr(owc_pkg::OFS_SYS_CTRL, 32'he0);
    wr(owc_pkg::OFS_SYS_CTRL, 32'h60);
    chk("sel", 32'h1, 32'(sysclk_sel_low));
    chk("hf en", 32'h0, 32'(hf_osc_en));
    wr(owc_pkg::OFS_IRQ_STATUS, 32'h1);
    chk("w1c", 32'h0, 32'(warmup_match_irq));
    wr(owc_pkg::OFS_UPPER_CTRL, 32'h0d);
    lf_on <= 1;
    repeat (100) @(posedge pclk);
    wr(owc_pkg::OFS_UPPER_CTRL, 32'h05);
    rd(owc_pkg::OFS_COUNT, 32'h0, "stop");
    repeat (1200) @(posedge pclk);
    chk("idle", 32'h0, 32'(warmup_match_irq));
    lf_on <= 0;
    wr(owc_pkg::OFS_SYS_CTRL, 32'he0);
    chk("hf on", 32'h1, 32'(hf_osc_en));
    wr(owc_pkg::OFS_LOWER_CTRL, 32'h63);
    wr(owc_pkg::OFS_COMPARE, 32'h0100);
    wr(owc_pkg::OFS_UPPER_CTRL, 32'h0d);
    hs <= 1;
    nt = 0;
    hf_on <= 1;
    wi(32'd257, "hf ticks");
    wr(owc_pkg::OFS_UPPER_CTRL, 32'h05);
    rd(owc_pkg::OFS_COUNT, 32'h0, "hf stop");
    wr(owc_pkg::OFS_SYS_CTRL, 32'hc0);
    chk("hf sel", 32'h0, 32'(sysclk_sel_low));
    wr(owc_pkg::OFS_SYS_CTRL, 32'h80);
    chk("lf off", 32'h0, 32'(lf_osc_en));
    wr(owc_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mask", 32'h0, 32'(warmup_match_irq));
    rd(owc_pkg::OFS_IRQ_STATUS, 32'h1, "sticky");
    wr(owc_pkg::OFS_IRQ_MASK, 32'h1);
    chk("unmask", 32'h1, 32'(warmup_match_irq));
    complete_run;
  end
endmodule
bind owc_top owc_asserts owc_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lf_tick(lf_tick), .hf_tick(hf_tick), .sysclk_sel_low(sysclk_sel_low),
  .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
  .warmup_match_irq(warmup_match_irq));
`default_nettype wire
